// [src/program_sequencer_pkg.sv]
package program_sequencer_pkg;

	// ==========================================================
	// Widths
	localparam int ADDR_WIDTH  = 13;
	localparam int DATA_WIDTH  = 8;
	localparam int WORD_WIDTH  = 16;
	localparam int STACK_DEPTH = 8;
	localparam int PHASES      = 4;
	localparam int IRQ_COUNT   = 5;

	// ==========================================================
	// Register offsets in data space
	localparam logic [7:0] PC_LOW_OFFSET       = 8'h06;
	localparam logic [7:0] TABLE_LOW_OFFSET    = 8'h07;
	localparam logic [7:0] TABLE_RESULT_OFFSET = 8'h08;
	localparam logic [7:0] TABLE_HIGH_OFFSET   = 8'h1F;

	// ==========================================================
	// Fixed program addresses
	localparam logic [12:0] RESET_VECTOR  = 13'h0000;
	localparam logic [12:0] VECTOR_STRIDE = 13'h0004;
	localparam logic [12:0] VECTOR_BASE   = 13'h0004;
	localparam logic [4:0]  LAST_PAGE     = 5'h1F;

	// ==========================================================
	// Reset values
	localparam logic [7:0] TABLE_LOW_RESET    = 8'h00;
	localparam logic [4:0] TABLE_HIGH_RESET   = 5'h00;
	localparam logic [7:0] TABLE_RESULT_RESET = 8'h00;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [1:0] PHASE_LAST  = 2'h3;

	// Commands that the decoder hands to the sequencer
	typedef enum logic [2:0] {
		OP_NEXT   = 3'h0,
		OP_SKIP   = 3'h1,
		OP_JUMP   = 3'h2,
		OP_CALL   = 3'h3,
		OP_SUB_RETURN = 3'h4,
		OP_INT_RETURN = 3'h5,
		OP_TABC   = 3'h6,
		OP_TABL   = 3'h7
	} op_type;

	typedef enum logic [1:0] {
		ST_FETCH = 2'b00,
		ST_EXEC  = 2'b01,
		ST_DUMMY = 2'b11
	} pipe_state_type;

endpackage

// [src/phase_generator.sv]
`timescale 1ns/1ps
module phase_generator
	import program_sequencer_pkg::*;
(
	input  wire logic       clock,  // System clock
	input  wire logic       resetn, // Sync reset, active low
	output logic [3:0]      phase,  // One-hot phase
	output logic            cycle_end // Last phase of cycle
);
	import program_sequencer_pkg::*;

	logic [1:0] count;

	// ==========================================================
	// Four non-overlapping phases
	always_ff @(posedge clock)
	begin
		if (!resetn)
			count <= PHASE_RESET;
		else
			count <= count + 2'h1;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			phase     <= 4'h1;
			cycle_end <= 1'b0;
		end
		else
		begin
			phase     <= 4'h1 << (count + 2'h1);
			cycle_end <= (count + 2'h1) == PHASE_LAST;
		end
	end

	AST_ONE_PHASE: assert property (@(posedge clock) disable iff (!resetn)
		$onehot(phase))
		else $error("phase not one-hot");
	AST_CYCLE_FOUR: assert property (@(posedge clock) disable iff (!resetn)
		cycle_end |=> !cycle_end [*3] ##1 cycle_end)
		else $error("instruction cycle not four clocks");
endmodule

// [src/return_stack.sv]
`timescale 1ns/1ps
module return_stack
	import program_sequencer_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int WIDTH = ADDR_WIDTH
)(
	input  wire logic             clock,  // System clock
	input  wire logic             resetn, // Sync reset, active low
	input  wire logic             push,   // Push request
	input  wire logic             pop,    // Pop request
	input  wire logic [WIDTH-1:0] push_data, // Return address
	output logic      [WIDTH-1:0] top_data,  // Top entry, registered
	output logic                  full,      // All levels used
	output logic                  empty      // No levels used
);
	import program_sequencer_pkg::*;

	localparam int PW = $clog2(DEPTH + 1);
	localparam int IW = $clog2(DEPTH);

	// Circular array: overflow overwrites the oldest entry
	logic [WIDTH-1:0] entry [DEPTH];
	logic [IW-1:0]    head;
	logic [PW-1:0]    level;

	// ==========================================================
	// Storage, hidden from software
	always_ff @(posedge clock)
	begin
		if (push)
			entry[head] <= push_data;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			head  <= '0;
			level <= '0;
		end
		else if (push)
		begin
			head <= head + IW'(1);
			if (level != PW'(DEPTH))
				level <= level + PW'(1);
		end
		else if (pop && level != '0)
		begin
			head  <= head - IW'(1);
			level <= level - PW'(1);
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			top_data <= '0;
		else if (push)
			top_data <= push_data;
		else if (pop)
			top_data <= entry[head - IW'(2)];
	end

	assign full  = level == PW'(DEPTH);
	assign empty = level == '0;

	AST_LEVEL_CAP: assert property (@(posedge clock) disable iff (!resetn)
		full && push |=> full)
		else $error("overflow changed level");
endmodule

// [src/program_sequencer.sv]
`timescale 1ns/1ps
// Functional notes
// - Instruction cycle is four clock periods in four phases.
// - Fetch overlaps execute; PC-changing instructions take two cycles.
// - 13-bit program address increments after each fetch.
// - Reset loads program address zero.
// - External interrupt vectors to 004H when enabled and stack not full.
// - Timer 0 overflow vectors to 008H when enabled, stack not full.
// - Timer 1 overflow vectors to 00CH when enabled, stack not full.
// - Timer 2 overflow vectors to 010H when enabled, stack not full.
// - Timer 3 overflow vectors to 014H when enabled, stack not full.
// - True skip discards prefetch, inserts dummy cycle, address plus two.
// - Write to low PC byte replaces eight bits, keeps page.
// - Jump and call load all thirteen bits from instruction.
// - Returns restore address from stack top.
// - Current-page table read uses both pointers; low to data, high to result.
// - Last-page table read forces bits 12 to 8 to ones.
// - Table result register is read-only, written by table reads only.
// - Eight-entry return stack, invisible to software.
// - Calls and interrupt acknowledges push the return address.
// - Reset leaves the stack empty.
// - Interrupts with full stack stay pending until a return pops.
// - Call on full stack still pushes, losing the oldest entry.
// - Table low pointer at 07H, high pointer at 1FH, read/write.
module program_sequencer
	import program_sequencer_pkg::*;
(
	input  wire logic                   clock,     // 20 MHz system clock
	input  wire logic                   resetn,    // Sync reset, active low
	input  wire logic [WORD_WIDTH-1:0]  rom_data,  // Program ROM word
	output logic      [ADDR_WIDTH-1:0]  rom_addr,  // Program ROM address
	output logic      [WORD_WIDTH-1:0]  instr,     // Instruction to decoder
	output logic                        instr_valid, // Pulse, new instruction
	input  wire program_sequencer_pkg::op_type op, // Decoded command
	input  wire logic                   op_valid,  // Command in last phase
	input  wire logic                   skip_true, // Skip condition met
	input  wire logic [ADDR_WIDTH-1:0]  op_target, // Address field
	input  wire logic [IRQ_COUNT-1:0]   irq_req,   // Latched request flags
	input  wire logic [IRQ_COUNT-1:0]   irq_en,    // Per-source enables
	input  wire logic                   irq_global_en, // Master enable
	output logic      [IRQ_COUNT-1:0]   irq_ack,   // Pulse, source acked
	input  wire logic                   reg_wr,    // Data-space write
	input  wire logic [7:0]             reg_addr,  // Data-space address
	input  wire logic [DATA_WIDTH-1:0]  reg_wdata, // Write data
	output logic      [DATA_WIDTH-1:0]  reg_rdata, // Registered read data
	output logic      [DATA_WIDTH-1:0]  table_low_data, // Low table byte
	output logic                        table_low_valid, // Pulse
	output logic      [4:0]             phase_out  // Phase, cycle end msb
);
	import program_sequencer_pkg::*;

	logic [3:0]            phase;
	logic                  cycle_end;
	logic [ADDR_WIDTH-1:0] pc;
	logic [ADDR_WIDTH-1:0] next_pc;
	logic [7:0]            table_pointer_low;
	logic [4:0]            table_pointer_high;
	logic [7:0]            table_read_high_byte;
	logic                  dummy;
	logic                  table_pending;
	logic [ADDR_WIDTH-1:0] table_addr;
	logic                  stack_push;
	logic                  stack_pop;
	logic [ADDR_WIDTH-1:0] stack_top;
	logic                  stack_full;
	logic                  stack_empty;
	logic [IRQ_COUNT-1:0]  irq_live;
	logic [IRQ_COUNT-1:0]  irq_pick;
	logic                  irq_take;
	logic [ADDR_WIDTH-1:0] irq_vector;
	logic                  pc_write;
	logic                  redirect;

	phase_generator u_phase (
		.clock     (clock),
		.resetn    (resetn),
		.phase     (phase),
		.cycle_end (cycle_end)
	);

	return_stack #(
		.DEPTH (STACK_DEPTH),
		.WIDTH (ADDR_WIDTH)
	) u_stack (
		.clock     (clock),
		.resetn    (resetn),
		.push      (stack_push),
		.pop       (stack_pop),
		.push_data (pc),
		.top_data  (stack_top),
		.full      (stack_full),
		.empty     (stack_empty)
	);

	// ==========================================================
	// Interrupt selection
	// Full stack holds requests off; flags stay pending outside
	assign irq_live = irq_req & irq_en
		& {IRQ_COUNT{irq_global_en && !stack_full}};
	assign irq_pick = irq_live & (~irq_live + IRQ_COUNT'(1));
	// Only between instructions, never during a dummy or table cycle
	assign irq_take = cycle_end && |irq_pick && !dummy && !table_pending
		&& !(op_valid && op != OP_NEXT);

	always_comb
	begin
		irq_vector = RESET_VECTOR;
		for (int i = 0; i < IRQ_COUNT; i++)
		begin
			if (irq_pick[i])
				irq_vector = VECTOR_BASE
					+ ADDR_WIDTH'(i) * VECTOR_STRIDE;
		end
	end

	assign pc_write = reg_wr && reg_addr == PC_LOW_OFFSET && cycle_end;
	assign stack_push = irq_take
		|| (cycle_end && op_valid && op == OP_CALL && !dummy);
	assign stack_pop = cycle_end && op_valid && !dummy
		&& (op == OP_SUB_RETURN || op == OP_INT_RETURN);

	// ==========================================================
	// Next program address
	always_comb
	begin
		next_pc  = pc;
		redirect = 1'b0;
		if (cycle_end)
		begin
			next_pc = pc + ADDR_WIDTH'(1);
			if (irq_take)
			begin
				next_pc  = irq_vector;
				redirect = 1'b1;
			end
			else if (pc_write)
			begin
				next_pc  = {pc[12:8], reg_wdata};
				redirect = 1'b1;
			end
			else if (op_valid && !dummy)
			begin
				unique case (op)
					OP_SKIP:
						if (skip_true)
						begin
							// Prefetched word already counted once
							next_pc  = pc + ADDR_WIDTH'(1);
							redirect = 1'b1;
						end
					OP_JUMP, OP_CALL:
					begin
						next_pc  = op_target;
						redirect = 1'b1;
					end
					OP_SUB_RETURN, OP_INT_RETURN:
					begin
						next_pc  = stack_top;
						redirect = 1'b1;
					end
					OP_TABC, OP_TABL, OP_NEXT:
						next_pc = pc + ADDR_WIDTH'(1);
				endcase
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			pc <= RESET_VECTOR;
		else if (cycle_end && !table_pending)
			pc <= next_pc;
	end

	// Dummy cycle after any control transfer, with prefetch discarded
	always_ff @(posedge clock)
	begin
		if (!resetn)
			dummy <= 1'b1;
		else if (cycle_end)
			dummy <= redirect;
	end

	// ==========================================================
	// Table read: one extra cycle with ROM on the table address
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			table_pending <= 1'b0;
			table_addr    <= RESET_VECTOR;
		end
		else if (cycle_end)
		begin
			table_pending <= !table_pending && op_valid && !dummy
				&& !irq_take && !pc_write
				&& (op == OP_TABC || op == OP_TABL);
			if (op == OP_TABL)
				table_addr <= {LAST_PAGE, table_pointer_low};
			else
				table_addr <= {table_pointer_high,
					table_pointer_low};
		end
	end

	// ==========================================================
	// ROM port and instruction register
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			rom_addr    <= RESET_VECTOR;
			instr       <= '0;
			instr_valid <= 1'b0;
		end
		else
		begin
			rom_addr    <= table_pending ? table_addr : pc;
			instr_valid <= cycle_end && !table_pending;
			if (cycle_end && !table_pending)
				instr <= rom_data;
		end
	end

	// ==========================================================
	// Data-space registers
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			table_pointer_low  <= TABLE_LOW_RESET;
			table_pointer_high <= TABLE_HIGH_RESET;
		end
		else if (reg_wr && reg_addr == TABLE_LOW_OFFSET)
			table_pointer_low <= reg_wdata;
		else if (reg_wr && reg_addr == TABLE_HIGH_OFFSET)
			table_pointer_high <= reg_wdata[4:0];
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			table_read_high_byte <= TABLE_RESULT_RESET;
			table_low_data       <= '0;
			table_low_valid      <= 1'b0;
		end
		else
		begin
			table_low_valid <= table_pending && cycle_end;
			if (table_pending && cycle_end)
			begin
				table_read_high_byte <= rom_data[15:8];
				table_low_data       <= rom_data[7:0];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			reg_rdata <= '0;
		else
			unique case (reg_addr)
				PC_LOW_OFFSET:       reg_rdata <= pc[7:0];
				TABLE_LOW_OFFSET:    reg_rdata <= table_pointer_low;
				TABLE_RESULT_OFFSET: reg_rdata <= table_read_high_byte;
				TABLE_HIGH_OFFSET:   reg_rdata <= {3'h0, table_pointer_high};
				default:     reg_rdata <= '0;
			endcase
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			irq_ack   <= '0;
			phase_out <= 5'h01;
		end
		else
		begin
			irq_ack   <= irq_take ? irq_pick : '0;
			phase_out <= {cycle_end, phase};
		end
	end

	// ==========================================================
	// Checks
	sequence seq_jump;
		cycle_end && op_valid && !dummy && !irq_take && !pc_write
			&& op == OP_JUMP;
	endsequence

	AST_RESET_PC: assert property (@(posedge clock)
		!resetn |=> pc == RESET_VECTOR)
		else $error("pc not zero after reset");
	AST_JUMP_LOAD: assert property (@(posedge clock) disable iff (!resetn)
		seq_jump |=> pc == $past(op_target))
		else $error("jump target not loaded");
	AST_JUMP_DUMMY: assert property (@(posedge clock) disable iff (!resetn)
		seq_jump |=> dummy [*4])
		else $error("no dummy cycle after jump");
	AST_INCR: assert property (@(posedge clock) disable iff (!resetn)
		cycle_end && !redirect && !table_pending
		|=> pc == $past(pc) + ADDR_WIDTH'(1))
		else $error("pc not incremented");
	AST_PCL_PAGE: assert property (@(posedge clock) disable iff (!resetn)
		cycle_end && pc_write && !irq_take && !table_pending
		|=> pc == {$past(pc[12:8]), $past(reg_wdata)})
		else $error("short jump left page");
	AST_FULL_HOLD: assert property (@(posedge clock) disable iff (!resetn)
		stack_full |-> !irq_take)
		else $error("interrupt taken on full stack");
	AST_TABLE_READ_HIGH_BYTE_ONLY: assert property (@(posedge clock) disable iff (!resetn)
		!(table_pending && cycle_end) |=> $stable(table_read_high_byte))
		else $error("result register changed outside table read");
	AST_LAST_PAGE: assert property (@(posedge clock) disable iff (!resetn)
		cycle_end && !table_pending && op_valid && op == OP_TABL && !dummy
		&& !irq_take && !pc_write
		|=> ##1 rom_addr[12:8] == LAST_PAGE)
		else $error("last page not forced");
endmodule

// [dv/rom_irq_model.sv]
`timescale 1ns/1ps
module rom_irq_model
	import program_sequencer_pkg::*;
(
	input  wire logic                  clock,    // System clock
	input  wire logic                  resetn,   // Sync reset, active low
	input  wire logic [ADDR_WIDTH-1:0] rom_addr, // Program address
	output logic      [WORD_WIDTH-1:0] rom_data, // Word at that address
	input  wire logic [IRQ_COUNT-1:0]  raise,    // Event pulses
	input  wire logic [IRQ_COUNT-1:0]  irq_ack,  // Acknowledge pulses
	output logic      [IRQ_COUNT-1:0]  irq_req   // Latched request flags
);
	// ==========================================================
	// Program memory
	// Pattern drawn from the address so any byte read is predictable
	assign rom_data = {3'h5, rom_addr[12:8], rom_addr[7:0] ^ 8'h5A};

	// ==========================================================
	// Request flags
	// Flags wait until acknowledged, so a full stack only delays them
	always_ff @(posedge clock)
		if (!resetn)
			irq_req <= '0;
		else
			irq_req <= (irq_req & ~irq_ack) | raise;
endmodule

// [dv/program_sequencer_tb_top.sv]
`timescale 1ns/1ps
module program_sequencer_tb_top;
	import program_sequencer_pkg::*;

	typedef struct {
		op_type      op;
		logic [12:0] tgt;
		logic        skip;
		logic        wr;
		logic [12:0] exp;
	} row_type;

	logic        clock = 1'h0;
	logic        resetn = 1'h0;
	logic [15:0] rom_data;
	logic [12:0] rom_addr;
	op_type      op = OP_NEXT;
	logic        op_valid = 1'h0;
	logic        skip_true = 1'h0;
	logic [12:0] op_target = 13'h0000;
	logic [4:0]  irq_req;
	logic [4:0]  irq_en = 5'h1F;
	logic        irq_global_en = 1'h1;
	logic [4:0]  irq_ack;
	logic [4:0]  raise = 5'h00;
	logic        reg_wr = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic [7:0]  table_low_data;
	logic        table_low_valid;
	logic [7:0]  lo_cap = 8'h00;
	logic [4:0]  phase_out;
	int          fail_count = 0;
	int          total_checks = 0;
	int          cycles = 0;

	row_type rows [7] = '{
		'{OP_JUMP, 13'h1234, 1'h0, 1'h0, 13'h1234},
		'{OP_CALL, 13'h0100, 1'h0, 1'h0, 13'h0100},
		'{OP_SUB_RETURN, 13'h0000, 1'h0, 1'h0, 13'h1235},
		'{OP_SKIP, 13'h0000, 1'h1, 1'h0, 13'h1237},
		'{OP_NEXT, 13'h0042, 1'h0, 1'h1, 13'h1242},
		'{OP_CALL, 13'h1FFF, 1'h0, 1'h0, 13'h1FFF},
		'{OP_INT_RETURN, 13'h0000, 1'h0, 1'h0, 13'h1243}
	};

	program_sequencer dut (
		.clock           (clock),
		.resetn          (resetn),
		.rom_data        (rom_data),
		.rom_addr        (rom_addr),
		.instr           (),
		.instr_valid     (),
		.op              (op),
		.op_valid        (op_valid),
		.skip_true       (skip_true),
		.op_target       (op_target),
		.irq_req         (irq_req),
		.irq_en          (irq_en),
		.irq_global_en   (irq_global_en),
		.irq_ack         (irq_ack),
		.reg_wr          (reg_wr),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_rdata       (reg_rdata),
		.table_low_data  (table_low_data),
		.table_low_valid (table_low_valid),
		.phase_out       (phase_out)
	);

	rom_irq_model model (
		.clock    (clock),
		.resetn   (resetn),
		.rom_addr (rom_addr),
		.rom_data (rom_data),
		.raise    (raise),
		.irq_ack  (irq_ack),
		.irq_req  (irq_req)
	);

	// ==========================================================
	// Clock, hang guard, table byte capture
	always #25 clock = ~clock;

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	// The low byte is flagged only by a one-clock valid pulse, so it is caught here
	always @(posedge clock)
		if (table_low_valid === 1'h1)
			lo_cap <= table_low_data;

	// ==========================================================
	// Helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Lands on the falling edge just before a cycle-end clock;
	// phase_out lags one clock, so its bit 2 marks that interval
	task automatic wait_end();
		@(negedge clock);
		repeat (7) if (phase_out[2] !== 1'h1) @(negedge clock);
	endtask

	// Commands are only looked at on the cycle-end clock
	task automatic issue(input row_type r);
		wait_end();
		op = r.op;
		op_target = r.tgt;
		skip_true = r.skip;
		op_valid = !r.wr;
		reg_wr = r.wr;
		reg_addr = 8'h06;
		reg_wdata = r.tgt[7:0];
		@(negedge clock);
		op_valid = 1'h0;
		reg_wr = 1'h0;
		skip_true = 1'h0;
		op = OP_NEXT;
		repeat (2) @(negedge clock);
		chk(16'(r.exp), 16'(rom_addr));
		// Step over the dummy or table cycle that follows
		wait_end();
		@(negedge clock);
	endtask

	task automatic wait_ack();
		@(negedge clock);
		repeat (40) if (irq_ack === 5'h00) @(negedge clock);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clock);
		reg_wr = 1'h0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		@(negedge clock);
		chk(16'(d), 16'(reg_rdata));
	endtask

	task automatic do_reset();
		resetn = 1'h0;
		repeat (3) @(negedge clock);
		chk(16'(rom_addr), 16'h0000);
		chk(16'(phase_out), 16'h0001);
		resetn = 1'h1;
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		int          n;
		logic [12:0] a;
		logic [4:0]  acc;
		do_reset();
		n = 0;
		for (int k = 0; k < 8; k++)
		begin
			@(negedge clock);
			chk(16'($onehot(phase_out[3:0])), 16'h0001);
			n += int'(phase_out[4]);
		end
		chk(16'(n), 16'h0002);
		wait_end();
		a = rom_addr;
		wait_end();
		chk(16'(rom_addr), 16'(a + 13'h0001));
		wait_end();
		@(negedge clock);
		foreach (rows[i])
			issue(rows[i]);
		raise = 5'h1F;
		@(negedge clock);
		raise = 5'h00;
		for (int i = 0; i < 5; i++)
		begin
			wait_ack();
			chk(16'(irq_ack), 16'(5'h01 << i));
			// The ROM address follows the new pc one clock later
			@(negedge clock);
			chk(16'(rom_addr), 16'(13'h004 + 13'(4 * i)));
		end
		do_reset();
		wait_end();
		@(negedge clock);
		for (int i = 0; i < 9; i++)
			issue('{OP_CALL, 13'h0300 + 13'(i), 1'h0, 1'h0,
				13'h0300 + 13'(i)});
		raise = 5'h02;
		@(negedge clock);
		raise = 5'h00;
		acc = 5'h00;
		repeat (16)
		begin
			@(negedge clock);
			acc |= irq_ack;
		end
		chk(16'(acc), 16'h0000);
		issue('{OP_SUB_RETURN, 13'h0000, 1'h0, 1'h0,
			13'h0308});
		wait_ack();
		chk(16'(irq_ack), 16'h0002);
		@(negedge clock);
		chk(16'(rom_addr), 16'h0008);
		reg_write(8'h07, 8'h34);
		reg_write(8'h1F, 8'h0A);
		reg_read(8'h07, 8'h34);
		reg_read(8'h1F, 8'h0A);
		issue('{OP_TABC, 13'h0000, 1'h0, 1'h0, 13'h0A34});
		repeat (4) @(negedge clock);
		chk(16'(lo_cap), 16'h006E);
		reg_read(8'h08, 8'hAA);
		reg_write(8'h08, 8'h00);
		reg_read(8'h08, 8'hAA);
		lo_cap = 8'h00;
		issue('{OP_TABL, 13'h0000, 1'h0, 1'h0, 13'h1F34});
		repeat (4) @(negedge clock);
		chk(16'(lo_cap), 16'h006E);
		reg_read(8'h08, 8'hBF);
		report_and_stop();
	end
endmodule
